//--- core/frt_icu_pkg.sv
// package: register map, field layout and shared types of the free-run timer with input capture
package frt_icu_pkg;

  localparam int          NUM_CH         = 4;
  localparam logic [7:0]  OFF_COUNT      = 8'h00;
  localparam logic [7:0]  OFF_CTRL       = 8'h04;
  localparam logic [7:0]  OFF_EDGE       = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0C;
  localparam logic [7:0]  OFF_MASK       = 8'h10;
  localparam logic [7:0]  OFF_CAP0       = 8'h14;
  localparam logic [7:0]  OFF_CAP3       = 8'h20;
  localparam logic [7:0]  OFF_XFER_SEL   = 8'h24;

  // counter_ctrl_status fields
  localparam int          CTRL_RUN       = 0;
  localparam int          CTRL_CLR       = 1;
  localparam int          CTRL_DIV_LO    = 2;
  localparam int          CTRL_DIV_W     = 2;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // status and mask: bit 0 overflow, bits 1..4 capture channels 0..3
  localparam int          ST_OVF         = 0;
  localparam int          ST_CAP_LO      = 1;
  localparam int          ST_W           = 5;

  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam int          PRE_W          = 8;
  localparam int          IRQ_NUM_OVF    = 19;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    EDGE_OFF     = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_FALL    = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_sel_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
  } axi_addr_t;

  typedef struct packed {
    logic [15:0] value;
    logic        tick;
  } time_base_t;

endpackage

//--- core/capture_channel.sv
// one capture channel: pin synchroniser, edge selection and latched count
module capture_channel (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // configuration and time base
  input  wire frt_icu_pkg::edge_sel_t edge_sel,
  input  wire frt_icu_pkg::time_base_t tb,
  // pin
  input  wire logic                   pin,
  // result
  output logic                        captured,
  output logic [15:0]                 cap_value
);
  import frt_icu_pkg::*;

  logic       sync_a;
  logic       sync_b;
  logic       prev;
  wire        rose;
  wire        fell;
  wire        hit;

  assign rose = sync_b & ~prev;
  assign fell = ~sync_b & prev;
  assign hit  = (rose & edge_sel[0]) | (fell & edge_sel[1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      prev      <= 1'b0;
      captured  <= 1'b0;
      cap_value <= COUNT_RESET;
    end else if (ce) begin
      sync_a   <= pin;
      sync_b   <= sync_a;
      prev     <= sync_b;
      captured <= hit;
      if (hit) begin
        cap_value <= tb.value;
      end
    end
  end

endmodule

//--- core/free_run_timer_input_capture.sv
// top: 16-bit free-run timer, four capture channels, AXI4-Lite register slave
//
// Summary of operation
// - A 16-bit up counter advances by one on every prescaler tick while it runs.
// - The prescaler divides aclk by one of four ratios chosen in the control register.
// - Overflow can raise an interrupt request, the one numbered 19 in the system.
// - The overflow request can be routed to the auto_transfer_service instead of the cpu.
// - The counter is zero after reset and after software writes the counter_clear_bit.
// - The live count is handed to every capture channel as its time base.
// - On the selected pin edge the count of that moment goes into the pin's data register.
// - Each channel detects rising edges, falling edges, or both.
// - A capture edge can raise a cpu interrupt for its channel.
// - A capture interrupt can start the auto_transfer_service.
// - Two capture units of two pins give four channels with their own data registers.
// - Reading the count register gives the live count; writes load it only while halted.
module free_run_timer_input_capture (
  // clock, reset, enable
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  // axi4-lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [7:0]                    s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // axi4-lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // axi4-lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [7:0]                    s_axi_araddr,
  // axi4-lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // capture pins, two units of two
  input  wire logic [frt_icu_pkg::NUM_CH-1:0] cap_pin,
  // interrupt and transfer-service requests
  output logic                               irq,
  output logic                               xfer_req
);
  import frt_icu_pkg::*;

  // ---------------- registers ----------------
  logic [15:0]           count;
  logic [PRE_W-1:0]      pre_cnt;
  logic                  run;
  logic [CTRL_DIV_W-1:0] div_sel;
  edge_sel_t             edge_sel [NUM_CH];
  logic [ST_W-1:0]       status;
  logic [ST_W-1:0]       mask;
  logic [ST_W-1:0]       xfer_sel;
  logic [15:0]           cap_value [NUM_CH];
  logic [NUM_CH-1:0]     captured;

  // ---------------- write channel ----------------
  axi_addr_t   aw;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        w_held;

  wire do_write = aw.valid & w_held & ~s_axi_bvalid;
  wire wr_count = do_write & (aw.addr == OFF_COUNT);
  wire wr_ctrl  = do_write & (aw.addr == OFF_CTRL);
  wire wr_edge  = do_write & (aw.addr == OFF_EDGE);
  wire wr_stat  = do_write & (aw.addr == OFF_STATUS);
  wire wr_mask  = do_write & (aw.addr == OFF_MASK);
  wire wr_xsel  = do_write & (aw.addr == OFF_XFER_SEL);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFF_XFER_SEL);
  endfunction

  // only low byte lanes carry fields; the clear bit honours lane 0
  wire lane0 = wstrb[0];
  wire lane1 = wstrb[1];
  wire clr_cmd = wr_ctrl & lane0 & wdata[CTRL_CLR];
  // a load while running is dropped, the counter owns itself then
  wire load_cmd = wr_count & ~run & (lane0 | lane1);

  // readies registered from the next held state, so they move exactly as a decode would
  wire next_aw_held = ~do_write & (aw.valid | (s_axi_awvalid & s_axi_awready));
  wire next_w_held  = ~do_write & (w_held | (s_axi_wvalid & s_axi_wready));
  wire next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw            <= '0;
      w_held        <= 1'b0;
      wdata         <= '0;
      wstrb         <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else if (ce) begin
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw.valid <= 1'b1;
        aw.addr  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        wdata  <= s_axi_wdata;
        wstrb  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw.valid     <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw.addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- prescaler and counter ----------------
  wire [PRE_W-1:0] pre_limit = PRE_W'((1 << (2 * div_sel)) - 1); // ratios 1,4,16,64
  // at or above the limit, so a smaller ratio chosen mid-count does not wait for a wrap
  wire             tick      = run & (pre_cnt >= pre_limit);
  wire             wrap      = tick & (count == COUNT_MAX);
  time_base_t      tb;

  assign tb.value = count;
  assign tb.tick  = tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count   <= COUNT_RESET;
      pre_cnt <= '0;
    end else if (ce) begin
      if (clr_cmd) begin
        count   <= COUNT_RESET;
        pre_cnt <= '0;
      end else if (load_cmd) begin
        if (lane0) count[7:0]  <= wdata[7:0];
        if (lane1) count[15:8] <= wdata[15:8];
      end else if (run) begin
        pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
        if (tick) begin
          count <= count + 16'h0001;
        end
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run      <= CTRL_RESET[CTRL_RUN];
      div_sel  <= CTRL_RESET[CTRL_DIV_LO +: CTRL_DIV_W];
      mask     <= '0;
      xfer_sel <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        edge_sel[i] <= EDGE_OFF;
      end
    end else if (ce) begin
      if (wr_ctrl & lane0) begin
        run     <= wdata[CTRL_RUN];
        div_sel <= wdata[CTRL_DIV_LO +: CTRL_DIV_W];
      end
      if (wr_edge & lane0) begin
        for (int i = 0; i < NUM_CH; i++) begin
          edge_sel[i] <= edge_sel_t'(wdata[2*i +: 2]);
        end
      end
      if (wr_mask & lane0) mask <= wdata[ST_W-1:0];
      if (wr_xsel & lane0) xfer_sel <= wdata[ST_W-1:0];
    end
  end

  // ---------------- capture channels ----------------
  // two units of two pins each, flattened into four channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    capture_channel u_ch (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .edge_sel  (edge_sel[c]),
      .tb        (tb),
      .pin       (cap_pin[c]),
      .captured  (captured[c]),
      .cap_value (cap_value[c])
    );
  end

  // ---------------- status, interrupt, transfer request ----------------
  wire [ST_W-1:0] events    = {captured, wrap};
  wire [ST_W-1:0] clr_bits  = (wr_stat & lane0) ? wdata[ST_W-1:0] : '0;
  // set beats clear so an event in the clearing cycle survives
  wire [ST_W-1:0] next_status = (status & ~clr_bits) | events;
  wire [ST_W-1:0] pending     = status & mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status   <= '0;
      irq      <= 1'b0;
      xfer_req <= 1'b0;
    end else if (ce) begin
      status <= next_status;
      // transfer-selected sources leave the cpu line, overflow is request 19
      irq      <= |(next_status & mask & ~xfer_sel);
      xfer_req <= |(next_status & mask & xfer_sel);
    end
  end

  // ---------------- read channel ----------------
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  wire        rd_go  = s_axi_arvalid & s_axi_arready;
  wire [1:0]  cap_ix = 2'((rd_addr - OFF_CAP0) >> 2);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      OFF_COUNT:    rd_mux[15:0] = count;
      OFF_CTRL:     rd_mux[CTRL_DIV_LO+CTRL_DIV_W-1:0] = {div_sel, 1'b0, run};
      OFF_EDGE:     rd_mux[2*NUM_CH-1:0] = {edge_sel[3], edge_sel[2], edge_sel[1], edge_sel[0]};
      OFF_STATUS:   rd_mux[ST_W-1:0] = status;
      OFF_MASK:     rd_mux[ST_W-1:0] = mask;
      OFF_XFER_SEL: rd_mux[ST_W-1:0] = xfer_sel;
      default: begin
        // misaligned capture offsets answer an error and must read zero
        if (mapped(rd_addr) && rd_addr >= OFF_CAP0 && rd_addr <= OFF_CAP3) begin
          rd_mux[15:0] = cap_value[cap_ix];
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr       <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rd_addr       <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end else if (!s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- verif/free_run_timer_input_capture_properties.sv
// checker: bus timing and request properties of the timer block
module timer_bus_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // requests
  input wire logic        irq,
  input wire logic        xfer_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import frt_icu_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  // both halves taken together: written at the next edge, answer seen the edge after
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 0) else $error("refused read returns data");
  AST_REQ_RST: assert property ($rose(aresetn) |-> !irq && !xfer_req)
    else $error("request high after reset");
endmodule

//--- verif/pin_source.sv
// far side: external signal sources on the four capture pins
module pin_source (
  // pins
  output logic [3:0] cap_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cap_pin = 4'h0;
  end
  // pins are async to aclk, so the lag lets a source be prompt or slow
  task automatic drive(input int c, input logic v, input int lag);
    #(lag);
    cap_pin[c] = v;
  endtask
endmodule

//--- verif/test_free_run_timer_input_capture.sv
// bench: registers, counter, capture and requests of the timer block
module test_free_run_timer_input_capture;
  timeunit 1ns;
  timeprecision 100ps;
  import frt_icu_pkg::*;
  typedef struct {logic [31:0] lo, hi; logic [1:0] er;} exp_t;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, xfer_req;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rnd;
  logic [1:0]  bresp, rresp;
  logic [3:0]  cap_pin;
  int          err_total, cmp_count, cyc;
  exp_t        q[$];
  pin_source src (.cap_pin(cap_pin));
  free_run_timer_input_capture dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .cap_pin(cap_pin), .irq(irq), .xfer_req(xfer_req));
  initial begin
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bready comes late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit ta, tw;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
                    input logic [1:0] er = RESP_OKAY);
    q.push_back('{lo, hi, er});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic rde(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    rd(a, v, v, er);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready && q.size() > 0) begin
      exp_t e;
      e = q.pop_front();
      chk(rdata, e.lo, e.hi);
      chk({30'h0, rresp}, {30'h0, e.er}, {30'h0, e.er});
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  initial begin
    rnd = 32'h0000_8abc;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rde(OFF_CTRL, CTRL_RESET);
    rde(OFF_COUNT, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001, RESP_SLVERR);
    rde(8'h30, 32'h0000_0000, RESP_SLVERR);
    for (int d = 0; d < 4; d++) begin
      wr(OFF_COUNT, 32'h0000_0000);
      wr(OFF_CTRL, (d << 2) | 1);
      wr(OFF_COUNT, 32'h0000_c000);
      repeat (256) @(posedge aclk);
      wr(OFF_CTRL, 32'h0000_0000);
      rd(OFF_COUNT, 256 >> (2 * d), (280 >> (2 * d)) + 1);
    end
    wr(OFF_CTRL, 32'h0000_0002);
    rde(OFF_COUNT, 32'h0000_0000);
    rde(OFF_CTRL, 32'h0000_0000);
    // pass 0 masked, pass 1 to the cpu, pass 2 to the transfer service
    for (int x = 0; x < 3; x++) begin
      wr(OFF_MASK, x != 0);
      wr(OFF_XFER_SEL, x == 2);
      wr(OFF_COUNT, 32'h0000_fffe);
      wr(OFF_CTRL, 32'h0000_0001);
      repeat (8) @(posedge aclk);
      wr(OFF_CTRL, 32'h0000_0000);
      chk(irq, x == 1, x == 1);
      chk(xfer_req, x == 2, x == 2);
      rde(OFF_STATUS, 32'h0000_0001);
      wr(OFF_STATUS, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk(irq | xfer_req, 0, 0);
    end
    wr(OFF_MASK, 32'h0000_001e);
    for (int c = 0; c < 4; c++) begin
      for (int m = 1; m < 4; m++) begin
        rnd = xs(rnd);
        wr(OFF_XFER_SEL, (m == 2) ? 32'h0000_001e : 32'h0000_0000);
        wr(OFF_EDGE, m << (2 * c));
        wr(OFF_COUNT, rnd[15:0]);
        src.drive(c, 1'b1, m);
        repeat (8) @(posedge aclk);
        wr(OFF_COUNT, rnd[31:16]);
        src.drive(c, 1'b0, 3 * m);
        repeat (8) @(posedge aclk);
        rde(8'(OFF_CAP0 + 4 * c), (m == 1) ? rnd[15:0] : rnd[31:16]);
        chk(irq, m != 2, m != 2);
        chk(xfer_req, m == 2, m == 2);
        rde(OFF_STATUS, 2 << c);
        wr(OFF_STATUS, 32'h0000_001f);
      end
    end
    results();
  end
endmodule
bind free_run_timer_input_capture timer_bus_props chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .irq(irq), .xfer_req(xfer_req));
